// ==== hw/adc_scan_sequencer.sv ====
// result fifo and scan sequencer with its register set
`timescale 1ns/1ps
`default_nettype none
module scan_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   // extra pointer bit tells full from empty; depth must be a power of two
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic [AW:0] fill;
   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;
   assign fill      = wp_r - rp_r;
   assign in_ready  = fill != DEPTH[AW:0];
   assign out_valid = wp_r != rp_r;
   assign out_data  = mem[rp_r[AW-1:0]];
   // storage has no reset, pointers do
   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wp_r[AW-1:0]] <= in_data;
   end
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_r + {{AW{1'b0}}, push};
         rp_r <= rp_r + {{AW{1'b0}}, pop};
      end
   end
endmodule : scan_fifo

module adc_scan_sequencer #(
   parameter logic [15:0] CHAN_AVAIL = scan_seq_pkg::CHAN_ALL,
   parameter int          CONV_CYC   = scan_seq_pkg::CONV_TIME_PERIODS
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // register port
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [23:0] reg_wdata,
   output logic [23:0]      reg_rdata,
   // converter side
   input  wire logic [15:0] conv_sample,
   output logic             conv_start,
   output logic             conv_busy,
   output logic [7:0]       mux_code,
   output logic [2:0]       gain_code,
   output logic [1:0]       adc_power_mode,
   // result stream
   output logic [19:0]      result_word,
   output logic             data_ready,
   output logic             scan_active
);
   import scan_seq_pkg::*;
   seq_state_t  state_r;
   logic [1:0]  adc_state_r, conversion_mode_select_r, fmt_r, pwr_r;
   logic [2:0]  gain_r, dly_r, gain_out_r;
   logic        az_r, start_r, busy_r, active_r, dready_r;
   logic [7:0]  insel_r, mux_out_r;
   logic [15:0] scan_en_r;
   logic [23:0] timer_r, cnt_r, rdata_r;
   logic [3:0]  chan_r;
   result_t     pend_r, res_r;
   // write strobes and register decode
   wire wr_state = reg_wr_en && (reg_addr == ADDR_STATE);
   wire wr_gain  = reg_wr_en && (reg_addr == ADDR_GAIN);
   wire wr_mode  = reg_wr_en && (reg_addr == ADDR_MODE);
   wire wr_insel = reg_wr_en && (reg_addr == ADDR_INSEL);
   wire wr_scan  = reg_wr_en && (reg_addr == ADDR_SCAN);
   wire wr_timer = reg_wr_en && (reg_addr == ADDR_TIMER);
   wire rd_res   = reg_rd_en && (reg_addr == ADDR_RESULT);
   wire scan_mode = |scan_en_r;
   wire running   = state_r != ST_IDLE;
   wire start_req = wr_state && (reg_wdata[1:0] == ADC_ON) && scan_mode;
   wire abort     = (wr_state && (reg_wdata[1:0] != ADC_ON)) || (running && !scan_mode);
   // next lower enabled channel
   function automatic logic [4:0] next_chan(input logic [15:0] en, input logic [4:0] from);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 0; i < NUM_CH; i++)
         if (en[i] && (5'(i) < from))
            res = {1'b1, 4'(i)};
      return res;
   endfunction : next_chan
   wire [4:0] first_hit = next_chan(scan_en_r, 5'h10);
   wire [4:0] next_hit  = next_chan(scan_en_r, {1'b0, chan_r});
   wire [23:0] conv_len = az_r ? 24'(2 * CONV_CYC) : 24'(CONV_CYC);
   // gap 0 or 8 << (code-1)
   wire [9:0]  dly_len  = (dly_r == 3'h0) ? 10'h000 : 10'(DLY_BASE << dly_r);
   // fifo joins
   logic    fifo_in_ready, fifo_out_valid;
   result_t fifo_out;
   wire fifo_push  = state_r == ST_PUSH;
   // drain when the result register is free or being read
   wire fifo_drain = rd_res || !dready_r;
   wire load_res   = fifo_out_valid && fifo_drain;
   wire push_ok    = fifo_push && fifo_in_ready;
   wire cycle_end  = push_ok && !next_hit[4];
   // one pass then standby or shutdown
   wire finish     = cycle_end && (conversion_mode_select_r != MODE_CONT);
   wire [1:0] finish_pwr = (conversion_mode_select_r == MODE_STANDBY) ? ADC_STANDBY : ADC_SHUTDOWN;
   // table and forced gains, input select ignored in scan
   wire [7:0] mux_nxt  = running ? MUX_TBL[chan_r] : insel_r;
   wire       force_1x = (chan_r == CH_TEMP) || (chan_r == CH_CMODE);
   wire [2:0] gain_nxt = !running ? gain_r : (chan_r == CH_SUPPLY) ? GAIN_THIRD : force_1x ? GAIN_ONE : gain_r;
   wire [1:0]  state_rd = running ? ADC_ON : adc_state_r;
   wire [23:0] rdata_nxt = (reg_addr == ADDR_RESULT) ? {4'h0, res_r} :
                           (reg_addr == ADDR_STATE)  ? {22'h0, state_rd} :
                           (reg_addr == ADDR_GAIN)   ? {21'h0, gain_r} :
                           (reg_addr == ADDR_MODE)   ? {19'h0, az_r, fmt_r, conversion_mode_select_r} :
                           (reg_addr == ADDR_INSEL)  ? {16'h0, insel_r} :
                           (reg_addr == ADDR_SCAN)   ? {1'b0, dly_r, 4'h0, scan_en_r} :
                           (reg_addr == ADDR_TIMER)  ? timer_r : 24'h000000;
   // configuration registers; overrides never write back here
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         gain_r      <= GAIN_ONE;
         conversion_mode_select_r <= ADC_SHUTDOWN;
         fmt_r       <= 2'h0;
         az_r        <= 1'b0;
         insel_r     <= 8'h00;
         scan_en_r   <= 16'h0000;
         dly_r       <= 3'h0;
         timer_r     <= 24'h000000;
      end
      else
      begin
         if (wr_gain)
            gain_r <= reg_wdata[2:0];
         if (wr_mode)
         begin
            conversion_mode_select_r <= reg_wdata[MODE_LSB +: 2];
            fmt_r       <= reg_wdata[FMT_LSB +: 2];
            az_r        <= reg_wdata[AZ_BIT];
         end
         if (wr_insel)
            insel_r <= reg_wdata[7:0];
         if (wr_scan)
         begin
            scan_en_r <= reg_wdata[15:0] & CHAN_AVAIL;
            dly_r     <= reg_wdata[DLY_LSB +: 3];
         end
         if (wr_timer)
            timer_r <= reg_wdata;
      end
   end
   // state held at 11 until finish or a state write
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         adc_state_r <= ADC_SHUTDOWN;
      else if (wr_state)
         adc_state_r <= reg_wdata[1:0];
      else if (finish)
         adc_state_r <= finish_pwr;
   end
   // sequencer on the modulator clock, idle after reset
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         chan_r  <= 4'h0;
         cnt_r   <= 24'h000000;
         start_r <= 1'b0;
         busy_r  <= 1'b0;
         pwr_r   <= ADC_SHUTDOWN;
         pend_r  <= '0;
      end
      else
      begin
         start_r <= 1'b0;
         if (abort)
         begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
            pwr_r   <= ADC_SHUTDOWN;
         end
         else if (start_req)
         begin
            state_r <= ST_CONV;
            chan_r  <= first_hit[3:0];
            cnt_r   <= conv_len;
            start_r <= 1'b1;
            busy_r  <= 1'b1;
            pwr_r   <= ADC_ON;
         end
         else
         begin
            case (state_r)
               ST_CONV:
                  if (cnt_r == 24'h000001)
                  begin
                     // tag with channel index in tagged format
                     state_r     <= ST_PUSH;
                     busy_r      <= 1'b0;
                     pend_r.data <= conv_sample;
                     pend_r.tag  <= (fmt_r == FMT_TAGGED) ? chan_r : 4'h0;
                  end
                  else
                     cnt_r <= cnt_r - 24'h000001;
               ST_PUSH:
                  if (fifo_in_ready)
                  begin
                     if (next_hit[4])
                     begin
                        chan_r <= next_hit[3:0];
                        if (dly_len == 10'h000)
                        begin
                           state_r <= ST_CONV;
                           cnt_r   <= conv_len;
                           start_r <= 1'b1;
                           busy_r  <= 1'b1;
                        end
                        else
                        begin
                           state_r <= ST_GAP;
                           cnt_r   <= {14'h0, dly_len};
                           pwr_r   <= ADC_STANDBY;
                        end
                     end
                     else if (conversion_mode_select_r == MODE_CONT)
                     begin
                        chan_r <= first_hit[3:0];
                        if (timer_r == 24'h000000)
                        begin
                           state_r <= ST_CONV;
                           cnt_r   <= conv_len;
                           start_r <= 1'b1;
                           busy_r  <= 1'b1;
                        end
                        else
                        begin
                           state_r <= ST_TIMER;
                           cnt_r   <= timer_r;
                           pwr_r   <= (timer_r > STARTUP_CYC) ? ADC_SHUTDOWN : ADC_STANDBY;
                        end
                     end
                     else
                     begin
                        state_r <= ST_IDLE;
                        pwr_r   <= finish_pwr;
                     end
                  end
               ST_GAP, ST_TIMER:
                  if (cnt_r == 24'h000001)
                  begin
                     state_r <= ST_CONV;
                     cnt_r   <= conv_len;
                     start_r <= 1'b1;
                     busy_r  <= 1'b1;
                     pwr_r   <= ADC_ON;
                  end
                  else
                  begin
                     // interval countdown, start-up from 256
                     // the intra-cycle gap stays in standby, so only the interval wakes early
                     cnt_r <= cnt_r - 24'h000001;
                     if (state_r == ST_TIMER && cnt_r == STARTUP_CYC + 24'h000001)
                        pwr_r <= ADC_ON;
                  end
               default:
                  state_r <= ST_IDLE;
            endcase
         end
      end
   end
   // buffered results; a full fifo stalls the walk in the push state
   scan_fifo #(.WIDTH($bits(result_t)), .DEPTH(4)) u_fifo (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (pend_r),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_drain),
      .out_data  (fifo_out)
   );
   // result register and data-ready level until read
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         res_r    <= '0;
         dready_r <= 1'b0;
      end
      else if (load_res)
      begin
         res_r    <= fifo_out;
         dready_r <= 1'b1;
      end
      else if (rd_res)
         dready_r <= 1'b0;
   end
   // registered outputs
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         mux_out_r  <= 8'h00;
         gain_out_r <= GAIN_ONE;
         active_r   <= 1'b0;
         rdata_r    <= 24'h000000;
      end
      else
      begin
         mux_out_r  <= mux_nxt;
         gain_out_r <= gain_nxt;
         active_r   <= running;
         if (reg_rd_en)
            rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata      = rdata_r;
   assign conv_start     = start_r;
   assign conv_busy      = busy_r;
   assign mux_code       = mux_out_r;
   assign gain_code      = gain_out_r;
   assign adc_power_mode = pwr_r;
   assign result_word    = res_r;
   assign data_ready     = dready_r;
   assign scan_active    = active_r;
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [24:0] busy_len_r;
   always_ff @(posedge sys_clk)
   begin
      if (reset || start_r)
         busy_len_r <= 25'h0000001;
      else if (busy_r)
         busy_len_r <= busy_len_r + 25'h0000001;
   end
   conv_length_a: assert property ($fell(busy_r) && !$past(abort) && $stable(az_r) |-> busy_len_r == 25'(conv_len))
      else $error("conversion length wrong");
   state_read_a: assert property (reg_rd_en && reg_addr == ADDR_STATE && running |=> rdata_r[1:0] == ADC_ON)
      else $error("state read not 11 during scan");
   mux_table_a: assert property (running && !abort && !start_req && state_r == ST_CONV |=> mux_code == MUX_TBL[chan_r])
      else $error("scan mux code mismatch");
   supply_gain_a: assert property (running && chan_r == CH_SUPPLY |=> gain_code == GAIN_THIRD)
      else $error("supply gain not forced");
   chan_order_a: assert property (push_ok && next_hit[4] && !abort && !start_req |=> chan_r < $past(chan_r))
      else $error("channel order not descending");
   one_shot_end_a: assert property (finish && !abort && !start_req && !wr_state |=> state_r == ST_IDLE && adc_state_r != ADC_ON)
      else $error("one-shot scan did not end");
   tag_field_a: assert property (fifo_push && fmt_r == FMT_TAGGED && $stable(fmt_r) && $past(state_r == ST_CONV) |-> pend_r.tag == chan_r)
      else $error("channel tag wrong");
   mode_write_a: assert property (wr_mode && state_r == ST_CONV && cnt_r > 24'h1 && !abort && !start_req |=> state_r == ST_CONV && !start_r)
      else $error("mode write disturbed conversion");
   result_ready_a: assert property (fifo_out_valid && !dready_r |=> dready_r && res_r == $past(fifo_out))
      else $error("result not presented");
   timer_launch_a: assert property (state_r == ST_TIMER && cnt_r == 24'h1 && !abort && !start_req |=> start_r && busy_r)
      else $error("timer did not launch cycle");
   one_shot_c: cover property (finish);
   timer_wait_c: cover property (state_r == ST_TIMER ##1 state_r == ST_CONV);
   gap_wait_c: cover property (state_r == ST_GAP ##1 state_r == ST_CONV);
   fifo_full_c: cover property (fifo_push && !fifo_in_ready);
endmodule : adc_scan_sequencer
`default_nettype wire

// ==== hw/scan_seq_pkg.sv ====
// constants, register map and types of the converter scan sequencer
package scan_seq_pkg;
   localparam int NUM_CH = 16;
   // register offsets
   localparam logic [4:0] ADDR_RESULT = 5'h00;
   localparam logic [4:0] ADDR_STATE  = 5'h01;
   localparam logic [4:0] ADDR_GAIN   = 5'h02;
   localparam logic [4:0] ADDR_MODE   = 5'h03;
   localparam logic [4:0] ADDR_INSEL  = 5'h06;
   localparam logic [4:0] ADDR_SCAN   = 5'h07;
   localparam logic [4:0] ADDR_TIMER  = 5'h08;
   // field positions
   localparam int MODE_LSB = 0;
   localparam int FMT_LSB  = 2;
   localparam int AZ_BIT   = 4;
   localparam int DLY_LSB  = 20;
   // field encodings
   localparam logic [1:0] ADC_SHUTDOWN = 2'h0;
   localparam logic [1:0] ADC_STANDBY  = 2'h2;
   localparam logic [1:0] ADC_ON       = 2'h3;
   localparam logic [1:0] MODE_CONT    = 2'h3;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] FMT_TAGGED   = 2'h3;
   localparam logic [2:0] GAIN_THIRD   = 3'h0;
   localparam logic [2:0] GAIN_ONE     = 3'h1;
   // channels with a forced gain
   localparam logic [3:0] CH_CMODE = 4'hf - 4'h1;
   localparam logic [3:0] CH_SUPPLY = 4'hd;
   localparam logic [3:0] CH_TEMP  = 4'hc;
   // timing in modulator clock periods, then the all-channel enable mask
   localparam int CONV_TIME_PERIODS = 256;
   localparam logic [23:0] STARTUP_CYC = 24'h000100;
   localparam logic [9:0]  DLY_BASE    = 10'h004;
   localparam logic [15:0] CHAN_ALL    = 16'hffff;
   // multiplexer code per enable bit, index 0 first
   localparam logic [7:0] MUX_TBL [NUM_CH] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58, 8'h68, 8'h78,
                                              8'h01, 8'h23, 8'h45, 8'h67, 8'hde, 8'h98, 8'hf8, 8'h88};
   typedef struct packed {
      logic [3:0]  tag;
      logic [15:0] data;
   } result_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CONV  = 3'b001,
      ST_PUSH  = 3'b010,
      ST_GAP   = 3'b011,
      ST_TIMER = 3'b100
   } seq_state_t;
endpackage : scan_seq_pkg

// ==== verif/conv_model.sv ====
// converter stand-in answering each conversion with a code-derived sample
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   // clock
   input  wire logic        sys_clk,
   // converter handshake
   input  wire logic        conv_busy,
   input  wire logic [7:0]  mux_code,
   output logic [15:0]      conv_sample
);
   logic [15:0] churn_r = 16'h0000;
   // outside a conversion the sample churns, so a grab at the wrong cycle never matches
   always_ff @(posedge sys_clk)
   begin
      churn_r <= churn_r + 16'h3b1d;
   end
   // the sample names the input that was selected, so the bench can tell channels apart
   assign conv_sample = conv_busy ? {~mux_code, mux_code} : churn_r;
endmodule : conv_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scan_seq_pkg::*;
   localparam int          N     = 4;
   localparam logic [15:0] AVAIL = 16'hf30f; // bits 11:10 and 7:4 absent
   logic        sys_clk, reset, reg_wr_en, reg_rd_en, conv_start, conv_busy, data_ready, scan_active;
   logic [4:0]  reg_addr;
   logic [23:0] reg_wdata, reg_rdata;
   logic [15:0] conv_sample;
   logic [7:0]  mux_code, mux_seen;
   logic [2:0]  gain_code, gain_seen;
   logic [1:0]  adc_power_mode;
   logic [19:0] result_word;
   logic [7:0]  q_mux[$];
   logic [2:0]  q_gain[$];
   int          q_len[$], q_gap[$];
   int          mismatches = 0, n_compared = 0, cycles = 0, len_r = 0, gap_r = 0, gap_last = 0;

   // short conversion keeps the run brief
   adc_scan_sequencer #(.CHAN_AVAIL(AVAIL), .CONV_CYC(N)) adc_scan_sequencer_inst (
      .sys_clk(sys_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_sample(conv_sample),
      .conv_start(conv_start), .conv_busy(conv_busy), .mux_code(mux_code), .gain_code(gain_code),
      .adc_power_mode(adc_power_mode), .result_word(result_word), .data_ready(data_ready),
      .scan_active(scan_active));
   conv_model conv_model_inst (.sys_clk(sys_clk), .conv_busy(conv_busy), .mux_code(mux_code),
      .conv_sample(conv_sample));

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // one record per conversion: code and gain at its last cycle, busy length, idle gap before it
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (conv_busy === 1'b1)
      begin
         len_r <= len_r + 1;
         mux_seen <= mux_code;
         gain_seen <= gain_code;
         gap_r <= 0;
      end
      else if (len_r != 0)
      begin
         q_mux.push_back(mux_seen);
         q_gain.push_back(gain_seen);
         q_len.push_back(len_r);
         q_gap.push_back(gap_last);
         len_r <= 0;
         gap_r <= 1;
      end
      else
         gap_r <= gap_r + 1;
      if (conv_start === 1'b1)
         gap_last <= gap_r;
      if (cycles == 20000)
      begin
         mismatches++;
         end_of_test;
      end
   end

   task automatic end_of_test;
      if (mismatches == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // register access: strobe for one cycle, read data lands the cycle after
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(negedge sys_clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [23:0] d);
      @(negedge sys_clk);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      d = reg_rdata;
   endtask : rd

   task automatic rd_chk(input string what, input logic [4:0] a, input logic [23:0] m, input logic [23:0] e);
      logic [23:0] d;
      rd(a, d);
      chk(what, e, d & m);
   endtask : rd_chk

   // bounded wait: 0 result ready, 1 sequencer idle, 2 conversion start
   task automatic waitfor(input int which);
      int k;
      k = 0;
      while (k < 2000 && !((which == 0 && data_ready === 1'b1) || (which == 1 && scan_active === 1'b0)
                           || (which == 2 && conv_start === 1'b1)))
      begin
         @(negedge sys_clk);
         k++;
      end
      // a wait that runs out is a failure, not a silent pass-through
      if (k >= 2000)
         chk("wait limit", 24'h1, 24'h0);
   endtask : waitfor

   function automatic logic [7:0] code_of(input int ch);
      case (ch)
         15: code_of = 8'h88;
         14: code_of = 8'hf8;
         13: code_of = 8'h98;
         12: code_of = 8'hde;
         11: code_of = 8'h67;
         10: code_of = 8'h45;
         9: code_of = 8'h23;
         8: code_of = 8'h01;
         default: code_of = {1'b0, ch[2:0], 4'h8};
      endcase
   endfunction : code_of

   // read every result of one cycle, highest channel first, and match it to its conversion
   task automatic drain_cycle(input logic [15:0] en, input logic az, input logic gap_on);
      logic [23:0] d;
      logic        first;
      int          gp;
      first = 1'b1;
      for (int ch = 15; ch >= 0; ch--)
      begin
         if (en[ch])
         begin
            waitfor(0);
            chk("result word", {4'h0, ch[3:0], ~code_of(ch), code_of(ch)}, {4'h0, result_word});
            rd(ADDR_RESULT, d);
            chk("result", {4'h0, ch[3:0], ~code_of(ch), code_of(ch)}, {4'h0, d[19:0]});
            chk("mux", code_of(ch), q_mux.pop_front());
            chk("gain", (ch == 13) ? GAIN_THIRD : (ch == 12 || ch == 14) ? GAIN_ONE : 3'h5,
                q_gain.pop_front());
            chk("busy length", az ? 2 * N : N, q_len.pop_front());
            gp = q_gap.pop_front();
            if (gap_on && !first)
               chk("intra gap", 24'h1, (gp >= 8 && gp <= 11));
            if (first)
               rd_chk("state running", ADDR_STATE, 24'h3, 24'h3);
            first = 1'b0;
         end
      end
   endtask : drain_cycle

   initial
   begin
      reset = 1'b1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 24'h000000;
      repeat (6) @(negedge sys_clk);
      reset = 1'b0;
      @(negedge sys_clk);
      chk("reset gain", 24'h1, gain_code);
      chk("reset outputs", 24'h0, {scan_active, adc_power_mode, data_ready, conv_busy});
      rd_chk("unmapped", 5'h1f, 24'hffffff, 24'h0);
      wr(ADDR_GAIN, 24'h5);
      wr(ADDR_INSEL, 24'h33);
      wr(ADDR_SCAN, 24'h0030f1);
      rd_chk("enables", ADDR_SCAN, 24'h00ffff, 24'h003001);
      // one-shot cycle to shutdown, tagged results, forced-gain channels
      wr(ADDR_MODE, 24'h00000c);
      wr(ADDR_STATE, 24'h000003);
      drain_cycle(16'h3001, 1'b0, 1'b0);
      waitfor(1);
      chk("power one-shot", ADC_SHUTDOWN, adc_power_mode);
      rd_chk("state one-shot", ADDR_STATE, 24'h3, 24'h0);
      rd_chk("gain kept", ADDR_GAIN, 24'h7, 24'h5);
      rd_chk("select kept", ADDR_INSEL, 24'hff, 24'h33);
      // one cycle to standby with auto-zero doubling the conversion
      wr(ADDR_SCAN, 24'h00c200);
      wr(ADDR_MODE, 24'h00001e);
      wr(ADDR_STATE, 24'h000003);
      drain_cycle(16'hc200, 1'b1, 1'b0);
      waitfor(1);
      chk("power standby", ADC_STANDBY, adc_power_mode);
      // repeating cycles, long interval, then a mode write mid-conversion ends them
      wr(ADDR_TIMER, 24'd300);
      wr(ADDR_SCAN, 24'h100003);
      wr(ADDR_MODE, 24'h00000f);
      wr(ADDR_STATE, 24'h000003);
      drain_cycle(16'h0003, 1'b0, 1'b1);
      repeat (20) @(negedge sys_clk);
      chk("power between cycles", ADC_SHUTDOWN, adc_power_mode);
      rd_chk("state between cycles", ADDR_STATE, 24'h3, 24'h3);
      waitfor(2);
      @(negedge sys_clk);
      chk("interval", 24'h1, (gap_last >= 300 && gap_last <= 304));
      wr(ADDR_MODE, 24'h00000d);
      drain_cycle(16'h0003, 1'b0, 1'b1);
      waitfor(1);
      chk("stop after cycle", 24'h0, {scan_active, adc_power_mode});
      // short interval idles in standby; a state write of 00 aborts the repeat
      wr(ADDR_TIMER, 24'd20);
      wr(ADDR_MODE, 24'h00000f);
      wr(ADDR_STATE, 24'h000003);
      drain_cycle(16'h0003, 1'b0, 1'b1);
      chk("power short interval", ADC_STANDBY, adc_power_mode);
      wr(ADDR_STATE, 24'h000000);
      waitfor(1);
      chk("abort", 24'h0, {scan_active, adc_power_mode});
      // no enables: back to single input, start refused
      wr(ADDR_SCAN, 24'h000000);
      wr(ADDR_STATE, 24'h000003);
      repeat (4) @(negedge sys_clk);
      chk("no scan", 24'h0, {conv_busy, scan_active});
      chk("single input code", 24'h33, mux_code);
      end_of_test;
   end
endmodule : tb_top
`default_nettype wire
